// file: include/fct_cfg.svh
// constants of the four channel interval timer: offsets, field positions, reset values
// assumes a 12-bit byte address on the peripheral bus and 32-bit data
`ifndef FCT_CFG_SVH
`define FCT_CFG_SVH

// ==========================================================
// structure
`define FCT_NCH        4
`define FCT_CW         24
`define FCT_AW         12
`define FCT_CNT_RST    24'hFFFFFF
`define FCT_IVAL_RST   24'h000000

// ==========================================================
// per-channel register offsets, word index in bits 3:2 of the byte address
`define FCT_OFF_INTVAL 2'h0
`define FCT_OFF_COUNT  2'h1
`define FCT_OFF_CTRL   2'h2
`define FCT_OFF_STAT   2'h3

// ==========================================================
// global register byte addresses
`define FCT_OFF_MODCFG 12'h0F0
`define FCT_OFF_IDLE   12'h0F4
`define FCT_OFF_IRQ    12'h0F8

// ==========================================================
// field positions
`define FCT_LOAD_BIT   31
`define FCT_MODE_LSB   1
`define FCT_MODE_MSB   2
`define FCT_STAT_FLAG  0
`define FCT_STAT_RUN   1

`endif

// file: include/fct_pkg.sv
// types shared by the interval timer modules
// assumes fct_cfg.svh is reachable on the include path
`include "fct_cfg.svh"

package fct_pkg;
    // channel operating modes, encoded as written into the control register
    typedef enum logic [1:0] {FCT_REPEAT, FCT_ONESHOT, FCT_STALL, FCT_RSVD} fct_mode_t;
    // bus answer sequencer
    typedef enum logic [1:0] {BUS_IDLE, BUS_DONE, BUS_WAIT, BUS_SDONE} fct_bus_st_t;
    typedef logic [`FCT_CW-1:0] fct_cnt_t;
endpackage

// file: include/fct_chan_if.sv
// carrier between the register front end and one counting channel
// assumes fct_pkg is compiled first
`timescale 1ns/100ps

interface fct_chan_if;
    import fct_pkg::*;
    logic      wr;
    logic      ld;
    fct_cnt_t  val;
    fct_mode_t mode;
    logic      clr;
    fct_cnt_t  cnt;
    fct_cnt_t  ival;
    logic      run;
    logic      flag;

    // front end drives commands, channel answers with its state
    modport ctl  (output wr, ld, val, mode, clr, input cnt, ival, run, flag);
    modport chan (input wr, ld, val, mode, clr, output cnt, ival, run, flag);
endinterface

// file: design/fct_chan.sv
// one down-counting channel of the interval timer
// assumes commands arrive as single-cycle pulses on pclk from the register front end
`timescale 1ns/100ps
`include "fct_cfg.svh"

module fct_chan
    import fct_pkg::*;
(
    // clock, reset, freeze
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    // command and state
    fct_chan_if.chan  c
);
    fct_cnt_t cnt_r;
    fct_cnt_t cnt_nxt;
    fct_cnt_t ival_r;
    fct_cnt_t ival_nxt;
    fct_cnt_t rld;
    logic     run_r;
    logic     run_nxt;
    logic     flag_r;
    logic     flag_nxt;
    logic     evt;

    // loaded value is always one less than the programmed interval
    function automatic fct_cnt_t minus1(input fct_cnt_t v);
        return v - fct_cnt_t'(1);
    endfunction

    // ==========================================================
    // counting
    // a deferred write must still be honoured when it lands on the zero cycle
    always_comb
    begin
        cnt_nxt  = cnt_r;
        run_nxt  = run_r;
        ival_nxt = ival_r;
        evt      = 1'b0;
        rld      = (c.wr && !c.ld) ? c.val : ival_r;
        if (c.wr)
            ival_nxt = c.val;
        if (c.wr && (c.ld || !run_r))
        begin
            if (c.val != '0)
            begin
                cnt_nxt = minus1(c.val);
                run_nxt = 1'b1;
            end
            else
                run_nxt = 1'b0;
        end
        else if (run_r)
        begin
            if (cnt_r == '0)
            begin
                evt = (c.mode != FCT_STALL);
                if (c.mode == FCT_REPEAT && rld != '0)
                    cnt_nxt = minus1(rld);
                else
                    run_nxt = 1'b0;
            end
            else
                cnt_nxt = cnt_r - fct_cnt_t'(1);
        end
        flag_nxt = (flag_r & ~c.clr) | evt;                // set beats clear
    end

    // state registers, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r  <= `FCT_CNT_RST;
            ival_r <= `FCT_IVAL_RST;
            run_r  <= 1'b0;
            flag_r <= 1'b0;
        end
        else if (ce)
        begin
            cnt_r  <= cnt_nxt;
            ival_r <= ival_nxt;
            run_r  <= run_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign c.cnt  = cnt_r;
    assign c.ival = ival_r;
    assign c.run  = run_r;
    assign c.flag = flag_r;
endmodule

// file: design/fct_top.sv
// four channel interval timer with an APB register slave
// assumes an APB3 master on pclk; no pins beyond the bus, the ce freeze input and the combined interrupt
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "fct_cfg.svh"

module fct_top
    import fct_pkg::*;
(
    // clock, reset, freeze
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [`FCT_AW-1:0] paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // combined interrupt
    output logic                  irq
);
    import fct_pkg::*;

    fct_chan_if ch_if[`FCT_NCH] ();

    fct_bus_st_t       bst_r;
    fct_bus_st_t       bst_nxt;
    fct_mode_t         mode_r   [`FCT_NCH];
    fct_mode_t         mode_nxt [`FCT_NCH];
    logic [31:0]       prdata_r;
    logic [31:0]       prdata_nxt;
    logic              pready_r;
    logic              pready_nxt;
    logic              pslverr_r;
    logic              pslverr_nxt;
    logic              irq_r;
    logic              irq_nxt;
    logic [1:0]        wch_r;
    logic [1:0]        wch_nxt;
    logic [`FCT_NCH-1:0] wr_c;
    logic [`FCT_NCH-1:0] clr_c;
    logic [`FCT_NCH-1:0] run_v;
    logic [`FCT_NCH-1:0] flag_v;
    fct_cnt_t          cnt_v    [`FCT_NCH];
    fct_cnt_t          ival_v   [`FCT_NCH];
    logic              acc;
    logic              ch_hit;
    logic [1:0]        ch;
    logic [1:0]        rg;
    logic              mapped;
    logic              stall_go;
    logic [31:0]       rdata;

    // ==========================================================
    // channels
    genvar gi;
    generate
        for (gi = 0; gi < `FCT_NCH; gi++)
        begin : g_ch
            assign ch_if[gi].wr   = wr_c[gi];
            assign ch_if[gi].ld   = pwdata[`FCT_LOAD_BIT];
            assign ch_if[gi].val  = pwdata[`FCT_CW-1:0];
            assign ch_if[gi].mode = mode_r[gi];
            assign ch_if[gi].clr  = clr_c[gi];
            assign run_v[gi]      = ch_if[gi].run;
            assign flag_v[gi]     = ch_if[gi].flag;
            assign cnt_v[gi]      = ch_if[gi].cnt;
            assign ival_v[gi]     = ch_if[gi].ival;

            // no shared state between channels
            fct_chan u_chan (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .c       (ch_if[gi])
            );
        end
    endgenerate

    // lowest-numbered idle channel, channel count when all run
    function automatic logic [2:0] first_idle(input logic [`FCT_NCH-1:0] r);
        logic [2:0] f;
        f = 3'(`FCT_NCH);
        for (int i = `FCT_NCH - 1; i >= 0; i--)
            if (!r[i])
                f = 3'(i);
        return f;
    endfunction

    // ==========================================================
    // address decode
    assign acc      = psel && penable;
    assign ch_hit   = (paddr[`FCT_AW-1:6] == '0);
    assign ch       = paddr[5:4];
    assign rg       = paddr[3:2];
    assign mapped   = ch_hit || paddr == `FCT_OFF_MODCFG || paddr == `FCT_OFF_IDLE || paddr == `FCT_OFF_IRQ;
    // stall only a nonzero interval write to a stall-mode channel
    assign stall_go = pwrite && ch_hit && rg == `FCT_OFF_INTVAL && mode_r[ch] == FCT_STALL
                      && pwdata[`FCT_CW-1:0] != '0;

    // read mux, unmapped and reserved bits read zero
    always_comb
    begin
        rdata = 32'h00000000;
        if (ch_hit)
        begin
            unique case (rg)
                `FCT_OFF_INTVAL: rdata = {8'h00, ival_v[ch]};
                `FCT_OFF_COUNT:  rdata = {8'h00, cnt_v[ch]};
                `FCT_OFF_CTRL:   rdata[`FCT_MODE_MSB:`FCT_MODE_LSB] = mode_r[ch];
                `FCT_OFF_STAT:   rdata[`FCT_STAT_RUN:`FCT_STAT_FLAG] = {run_v[ch], flag_v[ch]};
            endcase
        end
        else if (paddr == `FCT_OFF_MODCFG)
            rdata[3:0] = 4'(`FCT_NCH);
        else if (paddr == `FCT_OFF_IDLE)
            rdata[2:0] = first_idle(run_v);
        else if (paddr == `FCT_OFF_IRQ)
            rdata[`FCT_NCH-1:0] = flag_v;
    end

    // ==========================================================
    // bus sequencer: one wait state, or held until a stall delay ends
    // writes land on the edge that samples pready, except a stall start,
    // which must begin counting while the transfer is held
    always_comb
    begin
        bst_nxt     = bst_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        wch_nxt     = wch_r;
        wr_c        = '0;
        clr_c       = '0;
        for (int i = 0; i < `FCT_NCH; i++)
            mode_nxt[i] = mode_r[i];
        unique case (bst_r)
            BUS_IDLE:
            begin
                if (acc && stall_go)
                begin
                    wr_c[ch] = 1'b1;
                    wch_nxt  = ch;
                    bst_nxt  = BUS_WAIT;
                end
                else if (acc)
                begin
                    pready_nxt  = 1'b1;
                    pslverr_nxt = !mapped;
                    prdata_nxt  = pwrite ? 32'h00000000 : rdata;
                    bst_nxt     = BUS_DONE;
                end
            end
            BUS_DONE:
            begin
                bst_nxt = BUS_IDLE;
                if (pwrite && ch_hit)
                begin
                    unique case (rg)
                        `FCT_OFF_INTVAL: wr_c[ch] = 1'b1;
                        `FCT_OFF_COUNT:  wr_c[ch] = 1'b0;               // read-only, ignored
                        `FCT_OFF_CTRL:   mode_nxt[ch] = fct_mode_t'(pwdata[`FCT_MODE_MSB:`FCT_MODE_LSB]);
                        `FCT_OFF_STAT:   clr_c[ch] = pwdata[`FCT_STAT_FLAG];
                    endcase
                end
                else if (pwrite && paddr == `FCT_OFF_IRQ)
                    clr_c = pwdata[`FCT_NCH-1:0];
            end
            BUS_WAIT:
            begin
                // the channel went idle: the delay is over, complete the write
                if (!run_v[wch_r])
                begin
                    pready_nxt = 1'b1;
                    prdata_nxt = 32'h00000000;
                    bst_nxt    = BUS_SDONE;
                end
            end
            BUS_SDONE:
                bst_nxt = BUS_IDLE;
        endcase
        irq_nxt = |flag_v;
    end

    // bus and control registers, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bst_r     <= BUS_IDLE;
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r     <= 1'b0;
            wch_r     <= 2'h0;
            for (int i = 0; i < `FCT_NCH; i++)
                mode_r[i] <= FCT_REPEAT;
        end
        else if (ce)
        begin
            bst_r     <= bst_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r     <= irq_nxt;
            wch_r     <= wch_nxt;
            for (int i = 0; i < `FCT_NCH; i++)
                mode_r[i] <= mode_nxt[i];
        end
    end

    // all outputs straight from flops; no output pins beyond bus and interrupt
    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stall_held;
        bst_r == BUS_WAIT && run_v[wch_r];
    endsequence

    sequence s_stall_end;
        bst_r == BUS_WAIT && !run_v[wch_r] && ce;
    endsequence

    property p_stall_hold;
        s_stall_held |-> !pready_r;
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("pready during stall delay");

    property p_stall_done;
        s_stall_end |=> pready_r ##1 (bst_r == BUS_IDLE || !$past(ce));
    endproperty
    a_stall_done: assert property (p_stall_done) else $error("stall write not completed");

    property p_irq_any;
        ce |=> irq_r == $past(|flag_v);
    endproperty
    a_irq_any: assert property (p_irq_any) else $error("interrupt not the or of flags");

    property p_idle_reg;
        acc && !pwrite && bst_r == BUS_IDLE && paddr == `FCT_OFF_IDLE && ce
            |=> prdata_r[2:0] == first_idle($past(run_v)) && pready_r;
    endproperty
    a_idle_reg: assert property (p_idle_reg) else $error("wrong first idle channel");

    generate
        for (gi = 0; gi < `FCT_NCH; gi++)
        begin : g_chk
            property p_start;
                ce && wr_c[gi] && !run_v[gi] && ch_if[gi].val != '0
                    |=> run_v[gi] && cnt_v[gi] == $past(ch_if[gi].val) - fct_cnt_t'(1);
            endproperty
            a_start: assert property (p_start) else $error("idle channel did not load");

            property p_idle_zero;
                ce && wr_c[gi] && !run_v[gi] && ch_if[gi].val == '0 && !flag_v[gi]
                    |=> !run_v[gi] && !flag_v[gi];
            endproperty
            a_idle_zero: assert property (p_idle_zero) else $error("zero write started channel");

            property p_reload;
                ce && run_v[gi] && !wr_c[gi] && cnt_v[gi] == '0 && mode_r[gi] == FCT_REPEAT && ival_v[gi] != '0
                    |=> run_v[gi] && flag_v[gi] && cnt_v[gi] == $past(ival_v[gi]) - fct_cnt_t'(1);
            endproperty
            a_reload: assert property (p_reload) else $error("repeat reload wrong");

            property p_stop_now;
                ce && wr_c[gi] && run_v[gi] && ch_if[gi].ld && ch_if[gi].val == '0 && !flag_v[gi]
                    |=> !run_v[gi] && !flag_v[gi];
            endproperty
            a_stop_now: assert property (p_stop_now) else $error("immediate stop failed");

            property p_load_now;
                ce && wr_c[gi] && run_v[gi] && ch_if[gi].ld && ch_if[gi].val != '0 && !flag_v[gi]
                    |=> run_v[gi] && !flag_v[gi] && cnt_v[gi] == $past(ch_if[gi].val) - fct_cnt_t'(1);
            endproperty
            a_load_now: assert property (p_load_now) else $error("immediate reload failed");

            property p_defer;
                ce && wr_c[gi] && run_v[gi] && !ch_if[gi].ld && cnt_v[gi] > fct_cnt_t'(1)
                    |=> run_v[gi] && cnt_v[gi] == $past(cnt_v[gi]) - fct_cnt_t'(1);
            endproperty
            a_defer: assert property (p_defer) else $error("deferred write disturbed count");

            property p_oneshot_end;
                ce && run_v[gi] && !wr_c[gi] && cnt_v[gi] == '0 && mode_r[gi] == FCT_ONESHOT
                    |=> !run_v[gi] && flag_v[gi];
            endproperty
            a_oneshot_end: assert property (p_oneshot_end) else $error("one-shot end wrong");

            property p_dec;
                ce && run_v[gi] && !wr_c[gi] && cnt_v[gi] != '0 |=> cnt_v[gi] == $past(cnt_v[gi]) - fct_cnt_t'(1);
            endproperty
            a_dec: assert property (p_dec) else $error("counter did not step down");
        end
    endgenerate
endmodule

// file: dv/fct_apb_master.sv
// apb master standing in for the processor core on the peripheral bus
// assumes one pclk domain and a slave that may hold pready low for long
`timescale 1ns/100ps
`include "fct_cfg.svh"

module fct_apb_master
(
    // clock
    input  wire logic              pclk,
    // request
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [`FCT_AW-1:0]     paddr,
    output logic [31:0]            pwdata,
    // answer
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    // ==========================================================
    // bus idle at time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // ==========================================================
    // one transfer; no wait length assumed, only the bench watchdog ends a stalled write
    task automatic xfer(input logic w, input logic [`FCT_AW-1:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output int n);
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is taken at a rising edge; the request stands until that edge
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep the old value
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

// file: dv/fct_top_tb_top.sv
// self-checking bench of the four channel interval timer
// assumes fct_pkg, fct_chan_if and the design modules are compiled first
`timescale 1ns/100ps
`include "fct_cfg.svh"

module fct_top_tb_top;
    import fct_pkg::*;
    logic                 pclk;
    logic                 presetn;
    logic                 ce;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [`FCT_AW-1:0]   paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 irq;
    logic [31:0]          rd;
    logic                 err;
    int                   n_errors;
    int                   comparisons;
    int                   n;
    int                   c;

    // ==========================================================
    // clock, 8 ns
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    fct_top u_fct_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    fct_apb_master u_fct_apb_master (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ==========================================================
    // compare and bus helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [`FCT_AW-1:0] a, input logic [31:0] d);
        u_fct_apb_master.xfer(1'b1, a, d, rd, err, n);
        chk("write read data", 32'h0, rd);
    endtask
    task automatic rdc(input string what, input logic [`FCT_AW-1:0] a, input logic [31:0] exp);
        u_fct_apb_master.xfer(1'b0, a, 32'h0000_0000, rd, err, n);
        chk(what, exp, rd);
        chk({what, " error"}, 32'h0, {31'h0, err});
    endtask
    // counts cycles until irq, bounded so a dead channel cannot hang us
    task automatic wait_irq(input string what, input int lo, input int hi);
        c = 0;
        while (irq !== 1'b1 && c < 3000)
        begin
            @(posedge pclk);
            #1;
            c++;
        end
        chk(what, 32'h1, {31'h0, (c >= lo && c <= hi)});
    endtask
    task automatic quiet(input string what);
        repeat (50) @(posedge pclk);
        #1;
        chk(what, 32'h0, {31'h0, irq});
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // watchdog, far beyond the few hundred cycles the tests take
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        $display("watchdog expired");
        print_verdict();
    end

    // ==========================================================
    // tests
    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        n_errors = 0;
        comparisons = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("irq after reset", 32'h0, {31'h0, irq});
        rdc("counter reset", 12'h004, 32'h00FF_FFFF);
        rdc("first idle reset", 12'h0F4, 32'h0);
        rdc("channel count", 12'h0F0, 32'h4);
        u_fct_apb_master.xfer(1'b0, 12'h0FC, 32'h0, rd, err, n);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("test reset done");

        // repeat mode, long interval then load-now shortening
        wr(12'h000, 32'h0000_0028);
        rdc("first idle running", 12'h0F4, 32'h1);
        u_fct_apb_master.xfer(1'b0, 12'h004, 32'h0, rd, err, n);
        chk("counter loaded", 32'h1, {31'h0, rd <= 32'h27 && rd > 32'h1C});
        wait_irq("first interval", 25, 40);
        rdc("flag register", 12'h0F8, 32'h1);
        wr(12'h0F8, 32'h1);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        wait_irq("reload interval", 28, 40);
        wr(12'h00C, 32'h1);
        wr(12'h000, 32'h8000_0003);
        wait_irq("load-now interval", 0, 5);
        wr(12'h000, 32'h8000_0000);
        wr(12'h00C, 32'h1);
        quiet("repeat stopped");
        rdc("status stopped", 12'h00C, 32'h0);
        $display("test repeat done");

        // repeat mode, new interval without load-now waits for the next cycle
        wr(12'h000, 32'h0000_0010);
        wr(12'h000, 32'h0000_0005);
        wait_irq("old interval kept", 12, 14);
        rdc("interval readback", 12'h000, 32'h5);
        u_fct_apb_master.xfer(1'b0, 12'h004, 32'h0, rd, err, n);
        chk("new interval in use", 32'h1, {31'h0, rd <= 32'h4});
        wr(12'h000, 32'h8000_0000);
        wr(12'h00C, 32'h1);
        $display("test deferred done");

        // repeat mode, stop at end of interval
        wr(12'h030, 32'h0000_000C);
        wr(12'h030, 32'h0000_0000);
        wait_irq("final interval", 0, 12);
        wr(12'h03C, 32'h1);
        quiet("no reload after stop");
        $display("test stop at end done");

        // one-shot mode
        wr(12'h018, 32'h0000_0002);
        wr(12'h010, 32'h0000_0008);
        wait_irq("one-shot interval", 0, 10);
        rdc("one-shot idle flagged", 12'h01C, 32'h1);
        wr(12'h01C, 32'h1);
        quiet("one-shot single");
        wr(12'h010, 32'h0000_0040);
        wr(12'h010, 32'h8000_0006);
        wait_irq("one-shot reload", 5, 8);
        wr(12'h01C, 32'h1);
        wr(12'h010, 32'h0000_0020);
        wr(12'h010, 32'h8000_0000);
        quiet("one-shot stop");
        rdc("one-shot stop status", 12'h01C, 32'h0);
        $display("test one-shot done");

        // clock enable low freezes the count mid-interval
        wr(12'h010, 32'h0000_0008);
        ce <= 1'b0;
        repeat (30) @(posedge pclk);
        chk("frozen no irq", 32'h0, {31'h0, irq});
        ce <= 1'b1;
        wait_irq("count resumes", 8, 10);
        wr(12'h01C, 32'h1);
        $display("test freeze done");

        // zero to idle channel, then stall mode
        wr(12'h020, 32'h0000_0000);
        rdc("idle counter untouched", 12'h024, 32'h00FF_FFFF);
        wr(12'h028, 32'h0000_0004);
        rdc("control readback", 12'h028, 32'h4);
        wr(12'h020, 32'h0000_0014);
        chk("stall length", 32'h1, {31'h0, n >= 21 && n <= 30});
        rdc("stall status", 12'h02C, 32'h0);
        chk("stall no irq", 32'h0, {31'h0, irq});
        $display("test stall done");

        // reset in mid-run puts every channel back
        wr(12'h000, 32'h0000_0010);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("irq second reset", 32'h0, {31'h0, irq});
        rdc("counter second reset", 12'h004, 32'h00FF_FFFF);
        rdc("control second reset", 12'h028, 32'h0);
        rdc("status second reset", 12'h00C, 32'h0);
        $display("test second reset done");
        print_verdict();
    end
endmodule
